// file: inc/pcc_pkg.sv
// constants for the pixel chip configuration register bank
// assumes a single 125 mhz clock and a plain strobe register port
package pcc_pkg;

    // ==========================================================
    // register offsets (word addresses)
    localparam logic [7:0] ADDR_PIX_WINDOW  = 8'h00;
    localparam logic [7:0] ADDR_PIX_ROWSEL  = 8'h01;
    localparam logic [7:0] ADDR_PIX_COLSEL  = 8'h02;
    localparam logic [7:0] ADDR_PIXEL_WRITE_MODE    = 8'h03;
    localparam logic [7:0] ADDR_PGUARD_A    = 8'h04;
    localparam logic [7:0] ADDR_PGUARD_B    = 8'h05;
    localparam logic [7:0] ADDR_GGUARD_A    = 8'h06;
    localparam logic [7:0] ADDR_GGUARD_B    = 8'h07;
    localparam logic [7:0] ADDR_LEAK        = 8'h25;
    localparam logic [7:0] ADDR_COLRST      = 8'h2b;
    localparam logic [7:0] ADDR_RDTRIG      = 8'h34;
    localparam logic [7:0] ADDR_INJ         = 8'h36;
    localparam logic [7:0] ADDR_CAPRANGE    = 8'h3a;
    localparam logic [7:0] ADDR_PULSE_MASK  = 8'h3e;
    localparam logic [7:0] ADDR_PULSE_GO    = 8'h3f;
    localparam logic [7:0] ADDR_CLEAR_GO    = 8'h40;
    localparam logic [7:0] ADDR_MERGE       = 8'h46;
    localparam logic [7:0] ADDR_FMT_CFG     = 8'h4c;
    localparam logic [7:0] ADDR_OSC         = 8'h82;
    localparam logic [7:0] ADDR_FMT_SUM     = 8'h98;
    localparam logic [7:0] ADDR_ADC         = 8'h9b;

    // ==========================================================
    // pixel word fields
    localparam int PIX_EN_BIT     = 0;
    localparam int PIX_CAL_BIT    = 1;
    localparam int PIX_COLUMN_WIRED_OR_HIT_BIT  = 2;
    localparam int PIX_TRIM_LSB   = 3;
    localparam int PIX_SIGN_BIT   = 7;
    // pixel write mode fields
    localparam int MODE_ROW_AUTO  = 0;
    localparam int MODE_PARTIAL   = 1;
    localparam int MODE_BCAST     = 2;
    localparam int MODE_SAMPLE    = 3;
    localparam int MODE_UPSET     = 4;
    localparam int MODE_MULTI     = 5;
    // injection and range fields
    localparam int INJ_DIGITAL    = 7;
    localparam int INJ_ALT        = 6;
    localparam int CAP_RANGE_BIT  = 2;
    // pulse routing bits
    localparam int PULSE_CLR_LINK = 5;
    localparam int PULSE_CNT_RST  = 6;
    localparam int PULSE_CLR_CNT  = 7;
    localparam int PULSE_LINK_RST = 3;
    localparam int PULSE_ADC_GO   = 12;
    // merge fields
    localparam int MERGE_DBG_SEL  = 0;
    localparam int MERGE_CLK_SEL  = 8;
    localparam int MERGE_GATE     = 9;
    // format config fields
    localparam int FMT_RAW_BIT    = 7;
    localparam int FMT_MAXHIT_LSB = 0;
    localparam int FMT_MAXHIT_W   = 4;

    // ==========================================================
    // guard key, reset values and timing constants
    localparam logic [15:0] GUARD_KEY      = 16'hac75;
    localparam logic [15:0] MODE_RST       = 16'h0000;
    localparam logic [15:0] RDTRIG_RST     = 16'h0000;
    localparam logic [15:0] OSC_RST        = 16'h4100;
    localparam logic [7:0]  PIXEL_DEFAULT_GUARD    = 8'h00;
    localparam logic [15:0] GLOBAL_DEFAULT = 16'h0000;
    localparam logic [3:0]  DEFLOAD_CYCLES = 4'h8;
    localparam logic [3:0]  RD_DELAY_BASE  = 4'h2;
    localparam logic [3:0]  ADC_CONV_CYC   = 4'hc;

endpackage

// file: hw/pcc_bank.sv
// configuration register bank of the pixel readout chip
// assumes one clock, async active-high reset, plain strobe register port
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module pcc_bank #(
    parameter int ROWS = 8,                    // pixel rows
    parameter int COLS = 8                     // pixel columns (even)
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic        first_level_trigger,
    input  wire logic        read_trigger,
    input  wire logic [11:0] adc_sample,
    input  wire logic [15:0] dbg_word_pd,
    input  wire logic [15:0] dbg_word_cdr,
    output logic [7:0]       pixel_cfg_sel,
    output logic [15:0]      global_cfg_sel,
    output logic [15:0]      core_column_reset,
    output logic [15:0]      pulse_targets,
    output logic             readout_go,
    output logic             readout_clear,
    output logic [3:0]       general_purpose_output,
    output logic [7:0]       analog_ctrl
);

    // ==========================================================
    // storage
    logic [7:0]  pix_mem [ROWS*COLS];   // pixel words
    logic [15:0] row_sel;               // selected row
    logic [15:0] col_sel;               // selected column pair
    logic [15:0] pixel_write_mode;
    logic [15:0] pguard_a, pguard_b, gguard_a, gguard_b;
    logic [1:0]  leakage_and_gain_control;
    logic [15:0] core_column_reset_gate;
    logic [15:0] read_trigger_timing;
    logic [7:0]  injection_select;
    logic [15:0] capacitance_and_range;
    logic [15:0] pulse_routing_mask;
    logic [15:0] merge_options;
    logic [15:0] fmt_cfg;
    logic [14:0] oscillator_enables;
    logic [11:0] adc_result;
    logic [15:0] gcfg_prog;             // programmed global word
    logic [3:0]  defload_cnt;           // default load timer
    logic        pulse_go, clear_go;

    // one-bit-tolerant key compare, evaluated every cycle
    function automatic logic key_ok(input logic [15:0] v);
        logic [15:0] d;
        d = v ^ pcc_pkg::GUARD_KEY;
        return (d & (d - 16'h0001)) == 16'h0000;
    endfunction

    logic pix_guard_ok, glb_guard_ok;
    assign pix_guard_ok = key_ok(pguard_a) && key_ok(pguard_b);
    assign glb_guard_ok = key_ok(gguard_a) && key_ok(gguard_b);

    // ==========================================================
    // simple config registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pixel_write_mode         <= pcc_pkg::MODE_RST;
            row_sel                  <= 16'h0000;
            col_sel                  <= 16'h0000;
            pguard_a                 <= 16'h0000;
            pguard_b                 <= 16'h0000;
            gguard_a                 <= 16'h0000;
            gguard_b                 <= 16'h0000;
            leakage_and_gain_control <= 2'h0;
            core_column_reset_gate   <= 16'h0000;
            read_trigger_timing      <= pcc_pkg::RDTRIG_RST;
            injection_select         <= 8'h00;
            capacitance_and_range    <= 16'h0000;
            pulse_routing_mask       <= 16'h0000;
            merge_options            <= 16'h0000;
            fmt_cfg                  <= 16'h0000;
            oscillator_enables       <= pcc_pkg::OSC_RST[14:0];
        end else if (wr) begin
            case (addr)
                pcc_pkg::ADDR_PIX_ROWSEL: row_sel <= wdata;
                pcc_pkg::ADDR_PIX_COLSEL: col_sel <= wdata;
                pcc_pkg::ADDR_PIXEL_WRITE_MODE:   pixel_write_mode <= wdata;
                pcc_pkg::ADDR_PGUARD_A:   pguard_a <= wdata;
                pcc_pkg::ADDR_PGUARD_B:   pguard_b <= wdata;
                pcc_pkg::ADDR_GGUARD_A:   gguard_a <= wdata;
                pcc_pkg::ADDR_GGUARD_B:   gguard_b <= wdata;
                pcc_pkg::ADDR_LEAK:       leakage_and_gain_control <= wdata[1:0];
                pcc_pkg::ADDR_COLRST:     core_column_reset_gate <= wdata;
                pcc_pkg::ADDR_RDTRIG:     read_trigger_timing <= wdata;
                pcc_pkg::ADDR_INJ:        injection_select <= wdata[7:0];
                pcc_pkg::ADDR_CAPRANGE:   capacitance_and_range <= wdata;
                pcc_pkg::ADDR_PULSE_MASK: pulse_routing_mask <= wdata;
                pcc_pkg::ADDR_MERGE:      merge_options <= wdata;
                pcc_pkg::ADDR_FMT_CFG:    fmt_cfg <= wdata;
                pcc_pkg::ADDR_OSC:        oscillator_enables <= wdata[14:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // pixel window writes
    logic [15:0] pw;                  // write data for the window
    assign pw = wdata;
    always_ff @(posedge clock) begin
        if (!rst && wr && addr == pcc_pkg::ADDR_PIX_WINDOW) begin
            for (int c = 0; c < COLS; c++) begin
                if (row_sel < 16'(ROWS) &&
                    (pixel_write_mode[pcc_pkg::MODE_BCAST] ||
                     16'(c / 2) == col_sel)) begin
                    if (!pixel_write_mode[pcc_pkg::MODE_MULTI]) begin
                        pix_mem[row_sel*COLS + c] <= (c % 2 == 0) ? pw[7:0] : pw[15:8];
                    end else if (pixel_write_mode[pcc_pkg::MODE_PARTIAL]) begin
                        // five pixel bits per pixel in ten bits
                        pix_mem[row_sel*COLS + c][7:3] <=
                            (c % 2 == 0) ? pw[4:0] : pw[9:5];
                    end else begin
                        // three front-end bits per pixel
                        pix_mem[row_sel*COLS + c][2:0] <=
                            (c % 2 == 0) ? pw[2:0] : pw[7:5];
                    end
                end
            end
        end
    end

    // ==========================================================
    // global programmed word and default loading
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            defload_cnt <= 4'h0;
            gcfg_prog   <= 16'h0000;
        end else if (defload_cnt != pcc_pkg::DEFLOAD_CYCLES) begin
            defload_cnt <= defload_cnt + 4'h1;
            gcfg_prog   <= pcc_pkg::GLOBAL_DEFAULT;
        end else begin
            gcfg_prog <= {merge_options[7:0], injection_select};
        end
    end

    // configuration mux outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pixel_cfg_sel  <= pcc_pkg::PIXEL_DEFAULT_GUARD;
            global_cfg_sel <= pcc_pkg::GLOBAL_DEFAULT;
        end else begin
            pixel_cfg_sel  <= pix_guard_ok ? pix_mem[0] : pcc_pkg::PIXEL_DEFAULT_GUARD;
            global_cfg_sel <= glb_guard_ok ? gcfg_prog : pcc_pkg::GLOBAL_DEFAULT;
        end
    end

    // ==========================================================
    // pulse, clear, column reset, adc
    assign pulse_go = wr && addr == pcc_pkg::ADDR_PULSE_GO;
    assign clear_go = wr && addr == pcc_pkg::ADDR_CLEAR_GO;
    logic [3:0] adc_cnt;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pulse_targets     <= 16'h0000;
            core_column_reset <= 16'h0000;
            adc_cnt           <= 4'h0;
            adc_result        <= 12'h000;
        end else begin
            pulse_targets <= pulse_go ? pulse_routing_mask : 16'h0000;
            if (clear_go) begin
                pulse_targets[pcc_pkg::PULSE_LINK_RST] <=
                    pulse_routing_mask[pcc_pkg::PULSE_CLR_LINK];
                pulse_targets[pcc_pkg::PULSE_CNT_RST] <=
                    pulse_routing_mask[pcc_pkg::PULSE_CLR_CNT];
            end
            core_column_reset <= clear_go ? core_column_reset_gate : 16'h0000;
            if (pulse_go && pulse_routing_mask[pcc_pkg::PULSE_ADC_GO]) begin
                adc_cnt <= pcc_pkg::ADC_CONV_CYC;
            end else if (adc_cnt != 4'h0) begin
                adc_cnt <= adc_cnt - 4'h1;
                if (adc_cnt == 4'h1) begin
                    adc_result <= adc_sample;
                end
            end
        end
    end

    // ==========================================================
    // trigger timing
    logic [7:0] dec_cnt;
    logic       dec_busy, rt_seen;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dec_cnt       <= 8'h00;
            dec_busy      <= 1'b0;
            rt_seen       <= 1'b0;
            readout_go    <= 1'b0;
            readout_clear <= 1'b0;
        end else begin
            readout_go    <= 1'b0;
            readout_clear <= 1'b0;
            if (first_level_trigger && !dec_busy) begin
                dec_busy <= 1'b1;
                rt_seen  <= 1'b0;
                // decision time in high byte, read delay in low nibble
                // widen each term first so a large delay nibble keeps its carry
                dec_cnt  <= read_trigger_timing[15:8] +
                            8'(read_trigger_timing[3:0]) +
                            8'(pcc_pkg::RD_DELAY_BASE);
            end else if (dec_busy) begin
                if (read_trigger) rt_seen <= 1'b1;
                if (dec_cnt == 8'h00) begin
                    dec_busy      <= 1'b0;
                    readout_go    <= rt_seen || read_trigger;
                    readout_clear <= !(rt_seen || read_trigger);
                end else begin
                    dec_cnt <= dec_cnt - 8'h01;
                end
            end
        end
    end

    // ==========================================================
    // analog controls and debug output
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            analog_ctrl            <= 8'h00;
            general_purpose_output <= 4'h0;
        end else begin
            analog_ctrl <= {pixel_write_mode[pcc_pkg::MODE_SAMPLE],
                            merge_options[pcc_pkg::MERGE_CLK_SEL],
                            merge_options[pcc_pkg::MERGE_GATE],
                            capacitance_and_range[pcc_pkg::CAP_RANGE_BIT],
                            injection_select[pcc_pkg::INJ_DIGITAL],
                            injection_select[pcc_pkg::INJ_ALT],
                            leakage_and_gain_control};
            if (merge_options[pcc_pkg::MERGE_DBG_SEL]) begin
                general_purpose_output <= {dbg_word_pd[12], dbg_word_pd[8],
                                           dbg_word_pd[4], dbg_word_pd[0]};
            end else begin
                general_purpose_output <= {dbg_word_cdr[12], dbg_word_cdr[8],
                                           dbg_word_cdr[4], dbg_word_cdr[0]};
            end
        end
    end

    // summary mirrors config except bit 15 (sample mode) and bit 1 (max hits nonzero); raw map and max hits live in fmt_cfg
    logic [15:0] fmt_sum;
    always_comb begin
        fmt_sum     = fmt_cfg;
        fmt_sum[15] = pixel_write_mode[pcc_pkg::MODE_SAMPLE];
        fmt_sum[1]  = fmt_cfg[pcc_pkg::FMT_MAXHIT_LSB +: pcc_pkg::FMT_MAXHIT_W] != 4'h0;
    end

    // ==========================================================
    // read port, data one cycle after strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                pcc_pkg::ADDR_PIX_WINDOW: rdata <= (row_sel < 16'(ROWS) && col_sel < 16'(COLS/2)) ?
                    {pix_mem[row_sel*COLS + col_sel*2 + 1],
                     pix_mem[row_sel*COLS + col_sel*2]} : 16'h0000;
                pcc_pkg::ADDR_PIX_ROWSEL: rdata <= row_sel;
                pcc_pkg::ADDR_PIX_COLSEL: rdata <= col_sel;
                pcc_pkg::ADDR_PIXEL_WRITE_MODE:   rdata <= pixel_write_mode;
                pcc_pkg::ADDR_PGUARD_A:   rdata <= pguard_a;
                pcc_pkg::ADDR_PGUARD_B:   rdata <= pguard_b;
                pcc_pkg::ADDR_GGUARD_A:   rdata <= gguard_a;
                pcc_pkg::ADDR_GGUARD_B:   rdata <= gguard_b;
                pcc_pkg::ADDR_LEAK:       rdata <= {14'h0000, leakage_and_gain_control};
                pcc_pkg::ADDR_COLRST:     rdata <= core_column_reset_gate;
                pcc_pkg::ADDR_RDTRIG:     rdata <= read_trigger_timing;
                pcc_pkg::ADDR_INJ:        rdata <= {8'h00, injection_select};
                pcc_pkg::ADDR_CAPRANGE:   rdata <= capacitance_and_range;
                pcc_pkg::ADDR_PULSE_MASK: rdata <= pulse_routing_mask;
                pcc_pkg::ADDR_MERGE:      rdata <= merge_options;
                pcc_pkg::ADDR_FMT_CFG:    rdata <= fmt_cfg;
                pcc_pkg::ADDR_OSC:        rdata <= {1'b0, oscillator_enables};
                pcc_pkg::ADDR_FMT_SUM:    rdata <= fmt_sum;
                pcc_pkg::ADDR_ADC:        rdata <= {4'h0, adc_result};
                default:                  rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // ==========================================================
    // checks
    sequence clr_s;
        clear_go;
    endsequence
    guard_mux_a: assert property (@(posedge clock) disable iff (rst)
        !glb_guard_ok |=> global_cfg_sel == pcc_pkg::GLOBAL_DEFAULT)
        else $error("global defaults not selected");
    pix_mux_a: assert property (@(posedge clock) disable iff (rst)
        !pix_guard_ok |=> pixel_cfg_sel == pcc_pkg::PIXEL_DEFAULT_GUARD)
        else $error("pixel defaults not selected");
    // programmed words pass once both guards accept the key
    pix_prog_a: assert property (@(posedge clock) disable iff (rst)
        pix_guard_ok |=> pixel_cfg_sel == $past(pix_mem[0]))
        else $error("pixel programmed word not used");
    glb_prog_a: assert property (@(posedge clock) disable iff (rst)
        glb_guard_ok |=> global_cfg_sel == $past(gcfg_prog))
        else $error("global programmed word not used");
    col_reset_a: assert property (@(posedge clock) disable iff (rst)
        clr_s |=> core_column_reset == $past(core_column_reset_gate))
        else $error("column reset not gated");
    col_idle_a: assert property (@(posedge clock) disable iff (rst)
        !clear_go |=> core_column_reset == 16'h0000)
        else $error("column reset without clear");
    adc_hold_a: assert property (@(posedge clock) disable iff (rst)
        (adc_cnt == 4'h0) |=> $stable(adc_result))
        else $error("adc result changed idle");
    adc_done_a: assert property (@(posedge clock) disable iff (rst)
        pulse_go && pulse_routing_mask[pcc_pkg::PULSE_ADC_GO] |=> adc_cnt == pcc_pkg::ADC_CONV_CYC)
        else $error("adc conversion not started");
    pulse_route_a: assert property (@(posedge clock) disable iff (rst)
        pulse_go |=> pulse_targets == $past(pulse_routing_mask))
        else $error("pulse routing wrong");
    gpo_sel_a: assert property (@(posedge clock) disable iff (rst)
        merge_options[pcc_pkg::MERGE_DBG_SEL] && $stable(merge_options) |=>
        general_purpose_output == {$past(dbg_word_pd[12]), $past(dbg_word_pd[8]),
                                   $past(dbg_word_pd[4]), $past(dbg_word_pd[0])})
        else $error("debug output wrong");
    decide_a: assert property (@(posedge clock) disable iff (rst)
        readout_go |-> !readout_clear)
        else $error("readout and clear together");
    // decision pulse lands a fixed count after the taking edge
    sequence trig_take_s;
        first_level_trigger && !dec_busy && read_trigger_timing == 16'h0100;
    endsequence
    sequence decide_s;
        readout_go || readout_clear;
    endsequence
    decide_time_a: assert property (@(posedge clock) disable iff (rst)
        trig_take_s |-> ##4 !(readout_go || readout_clear) ##1 decide_s)
        else $error("decision pulse mistimed");
    // a read trigger inside the window must lead to readout
    rt_wins_a: assert property (@(posedge clock) disable iff (rst)
        dec_busy && dec_cnt == 8'h00 && (rt_seen || read_trigger) |=> readout_go)
        else $error("read trigger lost");
    // read data stands one cycle only, zero otherwise
    rd_idle_a: assert property (@(posedge clock) disable iff (rst)
        !rd |=> rdata == 16'h0000)
        else $error("read data without strobe");

endmodule

// file: verif/pcc_ctrl_model.sv
// readout controller model: answers a first-level trigger with a read trigger
// assumes the bench raises slow to withhold the answer past the decision time
`timescale 1ns/10ps
module pcc_ctrl_model (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic slow,
    input  wire logic first_level_trigger,
    output logic      read_trigger
);
    // ==========================================================
    // read trigger one cycle after the first-level trigger, or never
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            read_trigger <= 1'b0;
        end else begin
            read_trigger <= first_level_trigger & ~slow;
        end
    end
endmodule

// file: verif/pixel_chip_config_side_effects_tb_top.sv
// self-checking bench for the pixel chip configuration bank
// assumes the controller model on the trigger lines, one 125 mhz clock
`timescale 1ns/10ps
module pixel_chip_config_side_effects_tb_top;
    logic        clock, rst, wr, rd, rd_q, flt, rt, slow, go, clr;
    logic [7:0]  addr, pix, ana, inj;
    logic [15:0] wdata, rdata, pd, cdr, mg, glob, crst, pls;
    logic [11:0] adc;
    logic [3:0]  gp_out;
    logic [31:0] seed = 32'h3c, r, e;
    logic [31:0] q[$];                   // expected reads: {mask, value}
    int          num_errors = 0, n_checks = 0, cyc = 0;
    localparam logic [7:0]  TA [8] = '{8'h03, 8'h25, 8'h34, 8'h36, 8'h3a, 8'h3e, 8'h46, 8'h82};
    localparam logic [15:0] TM [8] = '{16'h3f, 16'h3, 16'hffff, 16'hff, 16'hffff,
                                       16'hffff, 16'hffff, 16'h7fff};
    localparam logic [15:0] K = pcc_pkg::GUARD_KEY;

    pcc_bank dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .first_level_trigger(flt), .read_trigger(rt), .adc_sample(adc),
        .dbg_word_pd(pd), .dbg_word_cdr(cdr), .pixel_cfg_sel(pix), .global_cfg_sel(glob),
        .core_column_reset(crst), .pulse_targets(pls), .readout_go(go),
        .readout_clear(clr), .general_purpose_output(gp_out), .analog_ctrl(ana));
    pcc_ctrl_model ctl (.clock(clock), .rst(rst), .slow(slow), .first_level_trigger(flt),
        .read_trigger(rt));

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [15:0] x, input logic [15:0] m);
        q.push_back({m, x});
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
    endtask
    task automatic settle();
        repeat (3) @(negedge clock);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================================
    // clock, timeout and read-data watcher
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        rd_q <= rd;
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    always @(negedge clock) begin
        if (rd_q) begin
            e = q.pop_front();
            chk(rdata & e[31:16], e[15:0]);
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        {rst, wr, rd, flt, slow, addr, wdata} = {1'b1, 28'h0};
        r = xs();
        pd = r[15:0];
        cdr = r[31:16];
        adc = 12'h0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rreg(pcc_pkg::ADDR_OSC, pcc_pkg::OSC_RST, 16'h7fff);
        rreg(pcc_pkg::ADDR_RDTRIG, 16'h0, 16'hffff);
        wreg(8'h10, 16'hffff);
        rreg(8'h10, 16'h0, 16'hffff);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            wreg(TA[i], r[15:0]);
            rreg(TA[i], r[15:0] & TM[i], TM[i]);
        end
        // pixel word, guards, broadcast and multi-write
        wreg(pcc_pkg::ADDR_PIXEL_WRITE_MODE, 16'h0);
        wreg(pcc_pkg::ADDR_PIX_ROWSEL, 16'h0);
        wreg(pcc_pkg::ADDR_PIX_COLSEL, 16'h0);
        wreg(pcc_pkg::ADDR_PIX_WINDOW, 16'h00a3);
        settle();
        chk({8'h0, pix}, {8'h0, pcc_pkg::PIXEL_DEFAULT_GUARD});
        wreg(pcc_pkg::ADDR_PGUARD_A, K ^ 16'h0100);
        wreg(pcc_pkg::ADDR_PGUARD_B, K);
        settle();
        chk({8'h0, pix}, 16'h00a3);
        wreg(pcc_pkg::ADDR_PGUARD_B, K ^ 16'h0003);
        settle();
        chk({8'h0, pix}, {8'h0, pcc_pkg::PIXEL_DEFAULT_GUARD});
        wreg(pcc_pkg::ADDR_PGUARD_B, K);
        wreg(pcc_pkg::ADDR_PIXEL_WRITE_MODE, 16'h0004);
        wreg(pcc_pkg::ADDR_PIX_COLSEL, 16'h0002);
        wreg(pcc_pkg::ADDR_PIX_WINDOW, 16'h5a5a);
        settle();
        chk({8'h0, pix}, 16'h005a);
        wreg(pcc_pkg::ADDR_PIXEL_WRITE_MODE, 16'h0022);
        wreg(pcc_pkg::ADDR_PIX_COLSEL, 16'h0);
        wreg(pcc_pkg::ADDR_PIX_WINDOW, 16'h03a7);
        settle();
        chk({8'h0, pix}, 16'h003a);
        wreg(pcc_pkg::ADDR_PIXEL_WRITE_MODE, 16'h0020);
        wreg(pcc_pkg::ADDR_PIX_WINDOW, 16'h00a5);
        settle();
        chk({8'h0, pix}, 16'h003d);
        rreg(pcc_pkg::ADDR_PIX_WINDOW, 16'hed3d, 16'hffff);
        // global guards, debug output and analog controls
        r = xs();
        mg = r[15:0] | 16'h0001;
        inj = r[23:16];
        wreg(pcc_pkg::ADDR_MERGE, mg);
        wreg(pcc_pkg::ADDR_INJ, {8'h0, inj});
        settle();
        chk(glob, pcc_pkg::GLOBAL_DEFAULT);
        wreg(pcc_pkg::ADDR_GGUARD_A, K);
        wreg(pcc_pkg::ADDR_GGUARD_B, K ^ 16'h8000);
        settle();
        chk(glob, {mg[7:0], inj});
        chk({12'h0, gp_out}, {12'h0, pd[12], pd[8], pd[4], pd[0]});
        wreg(pcc_pkg::ADDR_MERGE, mg & 16'hfffe);
        wreg(pcc_pkg::ADDR_LEAK, 16'h0002);
        wreg(pcc_pkg::ADDR_CAPRANGE, 16'h0004);
        wreg(pcc_pkg::ADDR_PIXEL_WRITE_MODE, 16'h0018);
        settle();
        chk({12'h0, gp_out}, {12'h0, cdr[12], cdr[8], cdr[4], cdr[0]});
        chk({8'h0, ana},
            {8'h0, 1'b1, mg[8], mg[9], 1'b1, inj[7], inj[6], 2'b10});
        wreg(pcc_pkg::ADDR_FMT_CFG, 16'h0080);
        rreg(pcc_pkg::ADDR_FMT_SUM, 16'h8080, 16'h8082);
        // clear with column gate, then every routing bit alone
        r = xs();
        wreg(pcc_pkg::ADDR_COLRST, r[15:0]);
        wreg(pcc_pkg::ADDR_PULSE_MASK, 16'h00a0);
        wreg(pcc_pkg::ADDR_CLEAR_GO, 16'h0);
        @(negedge clock);
        chk(crst, r[15:0]);
        chk(pls, 16'h0048);
        for (int i = 0; i < 16; i++) begin
            wreg(pcc_pkg::ADDR_PULSE_MASK, 16'h0001 << i);
            wreg(pcc_pkg::ADDR_PULSE_GO, 16'h0);
            @(negedge clock);
            chk(pls, 16'h0001 << i);
            @(negedge clock);
            chk(pls, 16'h0);
        end
        // adc result holds between conversions
        @(posedge clock);
        adc <= r[27:16];
        wreg(pcc_pkg::ADDR_PULSE_MASK, 16'h1000);
        wreg(pcc_pkg::ADDR_PULSE_GO, 16'h0);
        repeat (20) @(posedge clock);
        adc <= ~r[27:16];
        rreg(pcc_pkg::ADDR_ADC, {4'h0, r[27:16]}, 16'h0fff);
        rreg(pcc_pkg::ADDR_ADC, {4'h0, r[27:16]}, 16'h0fff);
        // two-trigger decision: answered in time, then withheld
        wreg(pcc_pkg::ADDR_RDTRIG, 16'h0100);
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            slow <= i[0];
            flt  <= 1'b1;
            @(posedge clock);
            flt  <= 1'b0;
            for (int k = 0; k < 40 && go !== 1'b1 && clr !== 1'b1; k++) @(negedge clock);
            chk({14'h0, go, clr}, {14'h0, ~i[0], i[0]});
        end
        repeat (4) @(posedge clock);
        final_report();
    end
endmodule
